// >>> isg_consts.svh
// Constants for the programming-entry and user signature access block
`ifndef ISG_CONSTS_SVH
`define ISG_CONSTS_SVH
// Signature array geometry
`define ISG_SIG_BYTES 256
`define ISG_PAGE_BYTES 128
`define ISG_AW 8
`define ISG_ERASED_BYTE 8'hff
// Analog trim byte in the second page
`define ISG_TRIM_ADDR 8'h80
// Maker signature location of the factory trim copy
`define ISG_MAKER_TRIM_ADDR 16'h0008
// Application path sees the array at this offset
`define ISG_IAP_OFFSET 9'h100
// Serial command codes (frame: command, address high, address low, data)
`define ISG_OP_SIG_READ 8'h38
`define ISG_OP_SIG_WRITE 8'h3a
`define ISG_OP_MAKER_READ 8'h30
`define ISG_OP_CHIP_ERASE 8'h8a
// Frame byte positions
`define ISG_IDX_CMD 2'h0
`define ISG_IDX_ADDR_HI 2'h1
`define ISG_IDX_ADDR_LO 2'h2
`define ISG_IDX_DATA 2'h3
// Internal power-on reset, longest time and system clock rate
`define ISG_POR_US 100
`define ISG_CLK_MHZ 100
// Reset low to I/O release window in system clocks
`define ISG_IO_FLOAT_MIN_CYC 1
`define ISG_IO_FLOAT_MAX_CYC 2
// Synchroniser reset value: {toggle, select, reset pin}
`define ISG_SYNC_RST 3'h2
`endif

// >>> isg_isp_sig_access.sv
// Programming entry, serial link and user signature array of the device
`timescale 1ns/1ps
`default_nettype none
`include "isg_consts.svh"
module isg_isp_sig_access #(
  parameter int unsigned POR_CYCLES = `ISG_POR_US * `ISG_CLK_MHZ, // Power-on reset length
  parameter logic [7:0] FACTORY_TRIM = 8'h5a // Arbitrary factory trim copy
) (
  // System clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Serial programming link
  input wire logic sck_in,
  input wire logic ss_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  // Reset pin and I/O release
  input wire logic rst_n_pin_in,
  output logic io_drive_en_out,
  // Configuration levels
  input wire isg_pkg::isg_fuse_s fuse_in,
  // Application access
  input wire isg_pkg::isg_iap_req_s iap_in,
  output logic [7:0] iap_rdata_out,
  output logic iap_ack_out,
  // Status
  output logic isp_mode_out,
  output logic por_done_out,
  output logic [7:0] trim_out
);
  import isg_pkg::*;

  localparam int unsigned PW = $clog2(POR_CYCLES + 1);
  localparam logic [PW-1:0] POR_END = PW'(POR_CYCLES - 1);

  // Nonvolatile signature array, both pages
  logic [7:0] sig_mem [`ISG_SIG_BYTES];

  // Link domain state
  logic [6:0] rx_sh_reg;   // Incoming bits
  logic [2:0] bit_cnt_reg; // Bit position in byte
  logic [7:0] rx_byte_reg; // Last whole byte
  logic rx_tog_reg;        // Flips per received byte
  logic [6:0] tx_sh_reg;   // Outgoing bits
  logic miso_reg;

  // System domain state
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic tog_seen_reg;
  isg_state_e state_reg;
  logic [PW-1:0] por_cnt_reg;
  logic por_done_reg;
  logic isp_mode_reg;
  logic [7:0] trim_reg;
  logic rst_pin_en_lat_reg;
  logic isp_en_lat_reg;
  logic [1:0] byte_idx_reg;
  logic [7:0] cmd_reg;
  logic [7:0] addr_hi_reg;
  logic [7:0] addr_lo_reg;
  logic [7:0] tx_byte_reg;
  logic miso_oe_reg;
  logic [7:0] iap_rdata_reg;
  logic iap_ack_reg;

  // Synchronised pin views and the events and enables decoded from them
  logic rst_pin_s;
  logic ss_s;
  logic rx_evt;
  logic frame_active;
  logic por_end_hit;
  logic data_evt;
  logic isp_wr_do;
  logic erase_do;
  logic iap_wr_do;

  // Address lies inside the external signature window
  function automatic logic sig_addr_ok(input logic [15:0] a);
    sig_addr_ok = (a[15:`ISG_AW] == '0);
  endfunction : sig_addr_ok

  // ---------------- Link clock domain ----------------

  // Sample on rising edge, most significant bit first
  always_ff @(posedge sck_in or posedge ss_n_in) begin
    if (ss_n_in) begin
      rx_sh_reg <= 7'h00;
      bit_cnt_reg <= 3'h0;
    end else begin
      rx_sh_reg <= {rx_sh_reg[5:0], mosi_in};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // Whole byte captured, toggle tells the system side
  always_ff @(posedge sck_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_byte_reg <= 8'h00;
      rx_tog_reg <= 1'b0;
    end else if (!ss_n_in && bit_cnt_reg == 3'h7) begin
      rx_byte_reg <= {rx_sh_reg, mosi_in};
      rx_tog_reg <= ~rx_tog_reg;
    end
  end

  // Shift out on falling edge; reply byte is loaded at byte boundary
  // The reply word is settled by the system side well before this edge
  always_ff @(negedge sck_in or posedge ss_n_in) begin
    if (ss_n_in) begin
      miso_reg <= 1'b0;
      tx_sh_reg <= 7'h00;
    end else if (bit_cnt_reg == 3'h0) begin
      miso_reg <= tx_byte_reg[7];
      tx_sh_reg <= tx_byte_reg[6:0];
    end else begin
      miso_reg <= tx_sh_reg[6];
      tx_sh_reg <= {tx_sh_reg[5:0], 1'b0};
    end
  end

  assign miso_out = miso_reg;

  // ---------------- System clock domain ----------------

  // Two-stage synchronisers: reset pin, select pin, byte toggle
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1_reg <= `ISG_SYNC_RST;
      sync2_reg <= `ISG_SYNC_RST;
    end else begin
      sync1_reg <= {rx_tog_reg, ss_n_in, rst_n_pin_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign rst_pin_s = sync2_reg[0];
  assign ss_s = sync2_reg[1];
  // I/O drivers follow the synchronised reset pin
  assign io_drive_en_out = sync2_reg[0];

  // Edge of the byte toggle
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tog_seen_reg <= 1'b0;
    end else begin
      tog_seen_reg <= sync2_reg[2];
    end
  end

  assign rx_evt = sync2_reg[2] ^ tog_seen_reg;
  assign por_end_hit = (state_reg == ISG_POR) && (por_cnt_reg == POR_END);
  // Link bytes count only inside a programming frame
  assign frame_active = (state_reg == ISG_ISP) && !ss_s;
  assign data_evt = rx_evt && frame_active && (byte_idx_reg == `ISG_IDX_DATA);

  // Power-on reset counter
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      por_cnt_reg <= '0;
    end else if (state_reg == ISG_POR && !por_end_hit) begin
      por_cnt_reg <= por_cnt_reg + PW'(1);
    end
  end

  // Operating state and entry paths
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= ISG_POR;
      isp_mode_reg <= 1'b0;
    end else begin
      case (state_reg)
        // Power-up entry: reset held low and select raised
        ISG_POR: begin
          if (por_end_hit) begin
            if (!rst_pin_s && ss_s) begin
              state_reg <= ISG_ISP;
              isp_mode_reg <= 1'b1;
            end else begin
              state_reg <= ISG_RUN;
            end
          end
        end
        // Entry from running only with both latched fuses on
        ISG_RUN: begin
          if (!rst_pin_s && ss_s && rst_pin_en_lat_reg && isp_en_lat_reg) begin
            state_reg <= ISG_ISP;
            isp_mode_reg <= 1'b1;
          end
        end
        // Session ends when reset returns high
        ISG_ISP: begin
          if (rst_pin_s) begin
            state_reg <= ISG_RUN;
            isp_mode_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= ISG_POR;
          isp_mode_reg <= 1'b0;
        end
      endcase
    end
  end

  // Reset-pin and programming fuses sampled at power-on and session end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rst_pin_en_lat_reg <= 1'b0;
      isp_en_lat_reg <= 1'b0;
    end else if (por_end_hit || (state_reg == ISG_ISP && rst_pin_s)) begin
      rst_pin_en_lat_reg <= fuse_in.rst_pin_en;
      isp_en_lat_reg <= fuse_in.isp_en;
    end
  end

  // Analog trim loaded once when power-on reset completes
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      por_done_reg <= 1'b0;
      trim_reg <= 8'h00;
    end else if (por_end_hit) begin
      por_done_reg <= 1'b1;
      trim_reg <= sig_mem[`ISG_TRIM_ADDR];
    end
  end

  // Frame assembly: command, address high, address low, data
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      byte_idx_reg <= `ISG_IDX_CMD;
      cmd_reg <= 8'h00;
      addr_hi_reg <= 8'h00;
      addr_lo_reg <= 8'h00;
      tx_byte_reg <= 8'h00;
    end else if (!frame_active) begin
      byte_idx_reg <= `ISG_IDX_CMD;
    end else if (rx_evt) begin
      byte_idx_reg <= byte_idx_reg + 2'h1;
      case (byte_idx_reg)
        `ISG_IDX_CMD: begin
          cmd_reg <= rx_byte_reg;
          tx_byte_reg <= 8'h00;
        end
        `ISG_IDX_ADDR_HI: begin
          addr_hi_reg <= rx_byte_reg;
        end
        // Reply prepared for the data byte; no lock check on reads
        `ISG_IDX_ADDR_LO: begin
          addr_lo_reg <= rx_byte_reg;
          if (cmd_reg == `ISG_OP_SIG_READ && sig_addr_ok({addr_hi_reg, rx_byte_reg})) begin
            tx_byte_reg <= sig_mem[rx_byte_reg];
          end else if (cmd_reg == `ISG_OP_MAKER_READ && {addr_hi_reg, rx_byte_reg} == `ISG_MAKER_TRIM_ADDR) begin
            tx_byte_reg <= FACTORY_TRIM;
          end else begin
            tx_byte_reg <= 8'h00;
          end
        end
        default: begin
          tx_byte_reg <= 8'h00;
        end
      endcase
    end
  end

  // External write needs the signature fuse and no lock
  assign isp_wr_do = data_evt && cmd_reg == `ISG_OP_SIG_WRITE && fuse_in.sig_prog_en &&
                     !fuse_in.lock_prog_block && sig_addr_ok({addr_hi_reg, addr_lo_reg});
  // Chip erase touches the array only with the signature fuse on
  assign erase_do = data_evt && cmd_reg == `ISG_OP_CHIP_ERASE && fuse_in.sig_prog_en;
  // Application path: own fuse, offset window, CPU running
  assign iap_wr_do = iap_in.req && iap_in.we && state_reg == ISG_RUN && fuse_in.iap_en &&
                     iap_in.addr[8];

  // Array write port; the second page is never erased
  always_ff @(posedge clk_in) begin
    if (erase_do) begin
      for (int i = 0; i < `ISG_PAGE_BYTES; i++) begin
        sig_mem[i] <= `ISG_ERASED_BYTE;
      end
    end else if (isp_wr_do) begin
      sig_mem[addr_lo_reg] <= rx_byte_reg;
    end else if (iap_wr_do) begin
      sig_mem[iap_in.addr[7:0]] <= iap_in.wdata;
    end
  end

  // Application read and acknowledge
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      iap_rdata_reg <= 8'h00;
      iap_ack_reg <= 1'b0;
    end else begin
      iap_ack_reg <= iap_in.req && state_reg == ISG_RUN;
      if (iap_in.req && !iap_in.we && iap_in.addr[8]) begin
        iap_rdata_reg <= sig_mem[iap_in.addr[7:0]];
      end else if (iap_in.req) begin
        iap_rdata_reg <= 8'h00;
      end
    end
  end

  // Reply line driven only inside a frame
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      miso_oe_reg <= 1'b0;
    end else begin
      miso_oe_reg <= frame_active;
    end
  end

  assign miso_oe_out = miso_oe_reg;
  assign iap_rdata_out = iap_rdata_reg;
  assign iap_ack_out = iap_ack_reg;
  assign isp_mode_out = isp_mode_reg;
  assign por_done_out = por_done_reg;
  assign trim_out = trim_reg;

  // ---------------- Checks ----------------

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // Reset pin fall followed by I/O release
  sequence s_rst_fall;
    $fell(rst_n_pin_in) ##1 !rst_n_pin_in;
  endsequence
  sequence s_io_released;
    ##[0:1] !io_drive_en_out;
  endsequence

  a_io_release_lag: assert property (s_rst_fall |-> s_io_released)
    else $error("I/O not released within two clocks of reset low");

  a_erase_page_two: assert property (erase_do |=>
      sig_mem[`ISG_TRIM_ADDR] == $past(sig_mem[`ISG_TRIM_ADDR]) && sig_mem[0] == `ISG_ERASED_BYTE)
    else $error("Chip erase did not clear page one or changed page two");

  a_sig_fuse_off: assert property (data_evt && !fuse_in.sig_prog_en && !iap_wr_do |=>
      sig_mem[$past(addr_lo_reg)] == $past(sig_mem[addr_lo_reg]))
    else $error("Signature changed with programming fuse off");

  a_iap_offset_write: assert property (iap_wr_do |=> sig_mem[$past(iap_in.addr[7:0])] == $past(iap_in.wdata))
    else $error("Application write missed its offset location");

  a_iap_low_ignored: assert property (iap_in.req && iap_in.we && !iap_in.addr[8] && !isp_wr_do && !erase_do |=>
      sig_mem[$past(iap_in.addr[7:0])] == $past(sig_mem[iap_in.addr[7:0]]))
    else $error("Application write below offset changed the array");

  a_por_trim_load: assert property (por_end_hit |=> por_done_out && trim_out == $past(sig_mem[`ISG_TRIM_ADDR]))
    else $error("Trim not loaded when power-on reset finished");

  a_por_bound: assert property (state_reg == ISG_POR |-> por_cnt_reg <= POR_END && !por_done_out)
    else $error("Power-on reset counter overran its limit");

  a_entry_gate: assert property (state_reg == ISG_RUN && !(rst_pin_en_lat_reg && isp_en_lat_reg) |=>
      state_reg != ISG_ISP)
    else $error("Entry from running accepted with fuses off");

  a_fuse_hold: assert property (state_reg == ISG_ISP && !rst_pin_s |=>
      $stable(rst_pin_en_lat_reg) && $stable(isp_en_lat_reg))
    else $error("Latched fuses changed during a session");

  a_idle_ignored: assert property (state_reg != ISG_ISP |=> byte_idx_reg == `ISG_IDX_CMD)
    else $error("Frame advanced outside programming state");

  a_read_always: assert property (rx_evt && frame_active && byte_idx_reg == `ISG_IDX_ADDR_LO &&
      cmd_reg == `ISG_OP_SIG_READ && addr_hi_reg == 8'h00 |=> tx_byte_reg == $past(sig_mem[rx_byte_reg]))
    else $error("Signature read reply wrong");

endmodule : isg_isp_sig_access
`default_nettype wire

// >>> isg_pkg.sv
// Types shared by the programming-entry and signature access block
package isg_pkg;
  // Fuse and lock levels seen by the block
  typedef struct packed {
    logic sig_prog_en;     // External signature programming allowed
    logic isp_en;          // Serial programming from a running device
    logic rst_pin_en;      // Reset pin acts as reset
    logic iap_en;          // Application programming allowed
    logic lock_prog_block; // Lock bits forbid external signature writes
  } isg_fuse_s;
  // Application-side access request
  typedef struct packed {
    logic req;
    logic we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } isg_iap_req_s;
  // Device operating state
  typedef enum logic [1:0] {
    ISG_POR,
    ISG_RUN,
    ISG_ISP
  } isg_state_e;
endpackage : isg_pkg

// >>> isg_prog_model.sv
// Programmer model: drives the serial link and the reset pin
`timescale 1ns/1ps
`default_nettype none
module isg_prog_model (
  // Pins toward the device
  output logic rst_n_out,
  output logic ss_n_out,
  output logic sck_out,
  output logic mosi_out,
  // Serial data back from the device
  input wire logic miso_in
);
  logic tick; // 30 ns link base clock
  // Idle pin levels at power-up
  initial begin
    rst_n_out = 1'b0; // Reset held low while power comes up
    ss_n_out = 1'b0;
    sck_out = 1'b0; // Clock idles low
    mosi_out = 1'b0;
  end
  // Base clock, phase unrelated to the system clock
  initial begin
    tick = 1'b0;
    #7;
    forever #15 tick = ~tick;
  end
  // Waits n base ticks
  task automatic wt(input int n);
    repeat (n) @(posedge tick);
  endtask : wt
  // Power-up entry: wait past 10 us, then raise select
  task automatic power_up();
    wt(340);
    ss_n_out = 1'b1;
  endtask : power_up
  // One four-byte frame as master, MSB first
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    ss_n_out = 1'b0;
    wt(2);
    for (int i = 31; i >= 0; i--) begin
      mosi_out = tx[i]; // Set up while clock is low
      wt(4); // Phases of 120 ns, period 240 ns
      sck_out = 1'b1;
      rx[i] = miso_in; // Sampled on the rising edge
      wt(4);
      sck_out = 1'b0;
    end
    wt(2); // Select lag after clock low
    ss_n_out = 1'b1;
    mosi_out = ~mosi_out; // Released line shows no stale value
    wt(20); // Write and erase time of the instant device
  endtask : frame
  // Leave programming: clock low, select high, release data, reset high
  task automatic isp_exit();
    sck_out = 1'b0;
    ss_n_out = 1'b1;
    mosi_out = ~mosi_out;
    wt(1); // Up to 30 ns, until the next base tick
    rst_n_out = 1'b1;
    wt(4);
  endtask : isp_exit
  // Enter programming from a running device
  task automatic isp_start();
    rst_n_out = 1'b0;
    ss_n_out = 1'b1;
    wt(5); // Tristate delay plus settling time
  endtask : isp_start
endmodule : isg_prog_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for programming entry and signature access
`timescale 1ns/1ps
`default_nettype none
`include "isg_consts.svh"
module tb_top;
  import isg_pkg::*;
  localparam int POR_CYC = 1500; // Shortened power-on reset
  localparam logic [7:0] TRIM = 8'h5a; // Arbitrary factory trim copy
  logic clk_in = 1'b0; // System clock
  logic sys_rst_in = 1'b1; // Power-on reset
  isg_fuse_s fuse = 5'h1e; // All fuses on, lock off
  isg_iap_req_s in_application_programming = '0; // Application request
  logic rst_n, ss_n, sck, mosi, miso, miso_oe, io_en, ack, isp, por_done;
  logic [7:0] rdata, trim, a, d;
  logic [7:0] ref_mem [256]; // Reference copy of the array
  logic [31:0] rx; // Last frame reply
  int mismatches = 0;
  int check_count = 0;
  int seed = 32'hd50e;
  wire logic miso_line = miso_oe ? miso : sck; // Released line toggles
  always #5 clk_in = ~clk_in;
  // Device under test
  isg_isp_sig_access #(.POR_CYCLES(POR_CYC), .FACTORY_TRIM(TRIM)) isg_isp_sig_access_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sck_in(sck), .ss_n_in(ss_n), .mosi_in(mosi),
    .miso_out(miso), .miso_oe_out(miso_oe), .rst_n_pin_in(rst_n), .io_drive_en_out(io_en),
    .fuse_in(fuse), .iap_in(in_application_programming), .iap_rdata_out(rdata), .iap_ack_out(ack), .isp_mode_out(isp),
    .por_done_out(por_done), .trim_out(trim));
  // Programmer on the far side
  isg_prog_model isg_prog_model_inst (
    .rst_n_out(rst_n), .ss_n_out(ss_n), .sck_out(sck), .mosi_out(mosi), .miso_in(miso_line));
  // Verdict and end of run
  task automatic final_report();
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // Byte comparison
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t byte got %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  // Flag comparison
  task automatic cmp1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : cmp1
  // Bounded wait for the programming state flag
  task automatic wait_isp(input logic v);
    for (int i = 0; i < 3000 && isp !== v; i++) @(posedge clk_in);
    #1;
  endtask : wait_isp
  // Serial frame with reference update; reply checked when live
  task automatic sop(input logic [7:0] cmd, input logic [7:0] al, input logic [7:0] dat, input logic live);
    logic [7:0] exp;
    exp = (cmd == `ISG_OP_SIG_READ) ? ref_mem[al] : ((cmd == `ISG_OP_MAKER_READ) ? TRIM : 8'h00);
    isg_prog_model_inst.frame({cmd, 8'h00, al, dat}, rx);
    if (live && cmd == `ISG_OP_SIG_WRITE && fuse.sig_prog_en && !fuse.lock_prog_block) ref_mem[al] = dat;
    if (live && cmd == `ISG_OP_CHIP_ERASE && fuse.sig_prog_en) begin
      for (int i = 0; i < `ISG_PAGE_BYTES; i++) ref_mem[i] = `ISG_ERASED_BYTE;
    end
    if (live) begin
      cmp8(rx[31:24] | rx[23:16] | rx[15:8], 8'h00);
      cmp8(rx[7:0], exp);
    end
  endtask : sop
  // Application access, one request pulse
  task automatic iop(input logic we, input logic [8:0] ad, input logic [7:0] dat, input logic run);
    @(negedge clk_in);
    in_application_programming = '{req: 1'b1, we: we, addr: ad, wdata: dat};
    @(negedge clk_in);
    in_application_programming.req = 1'b0;
    cmp1(ack, run);
    if (run && we && fuse.iap_en && ad[8]) ref_mem[ad[7:0]] = dat;
    if (run && !we) cmp8(rdata, ad[8] ? ref_mem[ad[7:0]] : 8'h00);
    @(negedge clk_in);
    cmp1(ack, 1'b0);
  endtask : iop
  // Watchdog against a hang
  initial begin
    #800000;
    mismatches++;
    final_report();
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 256; i++) begin
      ref_mem[i] = 8'($random(seed));
      isg_isp_sig_access_inst.sig_mem[i] = ref_mem[i];
    end
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    isg_prog_model_inst.power_up();
    wait_isp(1'b1);
    cmp1(isp, 1'b1);
    cmp1(por_done, 1'b1);
    cmp8(trim, ref_mem[`ISG_TRIM_ADDR]);
    // Writes and reads in the session
    for (int k = 0; k < 4; k++) begin
      a = 8'($random(seed));
      d = 8'($random(seed));
      sop(`ISG_OP_SIG_WRITE, a, d, 1'b1);
      sop(`ISG_OP_SIG_READ, a, 8'h00, 1'b1);
    end
    sop(`ISG_OP_MAKER_READ, 8'h08, 8'h00, 1'b1);
    iop(1'b0, 9'h100, 8'h00, 1'b0);
    @(negedge clk_in) fuse.lock_prog_block = 1'b1;
    sop(`ISG_OP_SIG_WRITE, 8'h21, ~ref_mem[8'h21], 1'b1);
    sop(`ISG_OP_SIG_READ, 8'h21, 8'h00, 1'b1);
    @(negedge clk_in) fuse = 5'h0e;
    sop(`ISG_OP_SIG_WRITE, 8'h22, ~ref_mem[8'h22], 1'b1);
    sop(`ISG_OP_CHIP_ERASE, 8'h00, 8'h00, 1'b1);
    sop(`ISG_OP_SIG_READ, 8'h22, 8'h00, 1'b1);
    @(negedge clk_in) fuse.sig_prog_en = 1'b1;
    sop(`ISG_OP_CHIP_ERASE, 8'h00, 8'h00, 1'b1);
    foreach (rx[j]) if (j < 4) sop(`ISG_OP_SIG_READ, 8'h7e + 8'(j), 8'h00, 1'b1);
    isg_prog_model_inst.isp_exit();
    wait_isp(1'b0);
    cmp1(io_en, 1'b1);
    // Application path with the external fuse off and lock on
    @(negedge clk_in) fuse = 5'h0b;
    for (int k = 0; k < 4; k++) begin
      a = 8'($random(seed));
      iop(1'b1, {1'b1, a}, 8'($random(seed)), 1'b1);
      iop(1'b0, {1'b1, a}, 8'h00, 1'b1);
      iop(1'b1, {1'b0, a}, 8'h77, 1'b1);
      iop(1'b0, {1'b0, a}, 8'h00, 1'b1);
    end
    @(negedge clk_in) fuse = 5'h1c;
    iop(1'b1, 9'h130, ~ref_mem[8'h30], 1'b1);
    sop(`ISG_OP_SIG_WRITE, 8'h30, ~ref_mem[8'h30], 1'b0);
    iop(1'b0, 9'h130, 8'h00, 1'b1);
    // Entry from a running device
    fork
      isg_prog_model_inst.isp_start();
      begin
        wait (rst_n === 1'b0); // Level wait, safe whichever branch runs first
        #1 cmp1(io_en, 1'b1);
        repeat (3) @(posedge clk_in);
        #1 cmp1(io_en, 1'b0);
      end
    join
    wait_isp(1'b1);
    cmp1(isp, 1'b1);
    @(negedge clk_in) fuse = 5'h10;
    sop(`ISG_OP_SIG_READ, 8'h90, 8'h00, 1'b1);
    isg_prog_model_inst.isp_exit();
    wait_isp(1'b0);
    isg_prog_model_inst.isp_start();
    repeat (20) @(posedge clk_in);
    #1 cmp1(isp, 1'b0);
    isg_prog_model_inst.isp_exit();
    // Whole array against the reference
    for (int i = 0; i < 256; i++) iop(1'b0, {1'b1, 8'(i)}, 8'h00, 1'b1);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
